/* File: logic/dmcrc_map.svh */
// Constants of the DMA memory CRC monitor
// Function
// - After the last beat the checksum is compared with zero for CRC-16 and with 0x2144DF1C for CRC-32.
// - On channel enable and descriptor fetch the checksum is reloaded from the destination word of the first descriptor.
// - Every beat from the source address onward is read and fed into the checksum until the block is covered.
// - A mismatch disables the channel, sets the CRC error status and transfer error flag; the interrupt only if enabled.
// - A match sets the transfer complete flag, interrupts only if enabled, and carries on with descriptor handling.
// - With a single descriptor in the list that same descriptor is fetched again after a good check.
// - After the last descriptor of the list and a good check the first descriptor is fetched next, so monitoring wraps.
// - After the fetch the block waits for a new trigger and repeats reload, read, calculate and compare.
`ifndef DMCRC_MAP_SVH
`define DMCRC_MAP_SVH
`define DMCRC_OFS_COUNT   32'h0000_0000
`define DMCRC_OFS_SOURCE  32'h0000_0004
`define DMCRC_OFS_DEST    32'h0000_0008
`define DMCRC_OFS_NEXT    32'h0000_000C
`define DMCRC_IDX_COUNT   2'h0
`define DMCRC_IDX_SOURCE  2'h1
`define DMCRC_IDX_DEST    2'h2
`define DMCRC_IDX_NEXT    2'h3
`define DMCRC_MAGIC32     32'h2144_DF1C
`define DMCRC_ZERO16      32'h0000_0000
`define DMCRC_POLY16      16'h1021
`define DMCRC_POLY32      32'hEDB8_8320
`define DMCRC_RST_WORD    32'h0000_0000
`define DMCRC_RST_COUNT   16'h0000
`define DMCRC_LIST_END    32'h0000_0000
`endif

/* File: logic/dmcrc_pkg.sv */
// Types of the DMA memory CRC monitor
package dmcrc_pkg;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_FETCH = 5'h02,
      ST_WAIT  = 5'h04,
      ST_READ  = 5'h08,
      ST_CHECK = 5'h10
   } dmcrc_state_t;
   typedef enum logic [1:0] {
      BEAT_BYTE = 2'h0,
      BEAT_HALF = 2'h1,
      BEAT_WORD = 2'h2
   } dmcrc_beat_t;
endpackage

/* File: logic/dmcrc_engine.sv */
// Combinational CRC-16/CRC-32 update for one memory beat
`timescale 1ns/1ps
`include "dmcrc_map.svh"
module dmcrc_engine (
   input  wire logic        i_poly32,
   input  wire logic [1:0]  i_width,
   input  wire logic [31:0] i_crc,
   input  wire logic [31:0] i_data,
   output logic      [31:0] o_crc
);
   // CRC-16 is MSB-first shift; CRC-32 is the reflected form
   function automatic logic [31:0] crc_byte(input logic        poly32,
                                            input logic [31:0] crc,
                                            input logic [7:0]  b);
      logic [31:0] c;
      c = poly32 ? (crc ^ {24'h000000, b}) : (crc ^ {16'h0000, b, 8'h00});
      for (int k = 0; k < 8; k++) begin
         if (poly32) begin
            c = c[0] ? ({1'b0, c[31:1]} ^ `DMCRC_POLY32) : {1'b0, c[31:1]};
         end else begin
            c = c[15] ? ({16'h0000, c[14:0], 1'b0}
                         ^ {16'h0000, `DMCRC_POLY16})
                      : {16'h0000, c[14:0], 1'b0};
         end
      end
      return c;
   endfunction

   wire [2:0] nbytes = (i_width == dmcrc_pkg::BEAT_BYTE) ? 3'h1 :
                       (i_width == dmcrc_pkg::BEAT_HALF) ? 3'h2 : 3'h4;

   // Lowest address byte first, so a stored MSB-first checksum ends last
   always_comb begin
      logic [31:0] c;
      c = i_crc;
      for (int j = 0; j < 4; j++) begin
         if (3'(j) < nbytes) begin
            c = crc_byte(i_poly32, c, i_data[8*j +: 8]);
         end
      end
      o_crc = c;
   end
endmodule

/* File: logic/dmcrc_monitor.sv */
// DMA channel memory CRC monitor: descriptor walk, beat reads, check
`timescale 1ns/1ps
`include "dmcrc_map.svh"
module dmcrc_monitor (
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_chan_enable,
   input  wire logic        i_crc_input_source,
   input  wire logic        i_crc_polynomial_select,
   input  wire logic [1:0]  i_crc_beat_width,
   input  wire logic [31:0] i_first_descriptor_addr,
   input  wire logic        i_trigger,
   input  wire logic        i_terr_int_enable,
   input  wire logic        i_tcmpl_int_enable,
   input  wire logic        i_clear_crc_error,
   input  wire logic        i_clear_transfer_error,
   input  wire logic        i_clear_transfer_complete,
   output logic             o_mem_req,
   output logic      [31:0] o_mem_addr,
   input  wire logic        i_mem_ack,
   input  wire logic [31:0] i_mem_rdata,
   output logic             o_channel_active,
   output logic      [31:0] o_running_checksum,
   output logic             o_channel_crc_error_status,
   output logic             o_channel_transfer_error_flag,
   output logic             o_channel_transfer_complete_flag,
   output logic             o_terr_irq,
   output logic             o_tcmpl_irq
);
   dmcrc_pkg::dmcrc_state_t state_q, state_d;
   logic        active_q, en_q, trig_q;
   logic [31:0] head_q, desc_q, src_q, next_q, chk_q, chk_d;
   logic [1:0]  idx_q;
   logic [15:0] cnt_q;
   logic        crc_err_q, terr_q, tcmpl_q;
   logic [31:0] beat_crc;

   function automatic logic [31:0] beat_step(input logic [1:0] w);
      return (w == dmcrc_pkg::BEAT_BYTE) ? 32'h0000_0001 :
             (w == dmcrc_pkg::BEAT_HALF) ? 32'h0000_0002 : 32'h0000_0004;
   endfunction

   wire in_fetch  = (state_q == dmcrc_pkg::ST_FETCH);
   wire in_read   = (state_q == dmcrc_pkg::ST_READ);
   wire in_check  = (state_q == dmcrc_pkg::ST_CHECK);
   wire in_wait   = (state_q == dmcrc_pkg::ST_WAIT);
   wire start     = i_chan_enable & ~en_q & i_crc_input_source;
   wire fetch_ack = in_fetch & i_mem_ack;
   wire read_ack  = in_read & i_mem_ack & (cnt_q != `DMCRC_RST_COUNT);
   wire read_done = in_read & ((cnt_q == `DMCRC_RST_COUNT) |
                               (i_mem_ack & (cnt_q == 16'h0001)));
   wire is_head   = (desc_q == head_q);
   wire last_desc = (next_q == `DMCRC_LIST_END) | (next_q == head_q);
   wire cmp_value = i_crc_polynomial_select ?
                    (chk_q == `DMCRC_MAGIC32) :
                    (chk_q[15:0] == 16'(`DMCRC_ZERO16));
   wire match     = in_check & cmp_value;
   wire mismatch  = in_check & ~cmp_value;
   wire advance   = (read_done & ~last_desc) | match;
   wire consume   = in_wait & trig_q;
   wire [31:0] fetch_ofs = (idx_q == `DMCRC_IDX_COUNT)  ? `DMCRC_OFS_COUNT  :
                           (idx_q == `DMCRC_IDX_SOURCE) ? `DMCRC_OFS_SOURCE :
                           (idx_q == `DMCRC_IDX_DEST)   ? `DMCRC_OFS_DEST   :
                                                          `DMCRC_OFS_NEXT;
   wire reload    = fetch_ack & (idx_q == `DMCRC_IDX_DEST) & is_head;

   dmcrc_engine u_engine (
      .i_poly32 (i_crc_polynomial_select),
      .i_width  (i_crc_beat_width),
      .i_crc    (chk_q),
      .i_data   (i_mem_rdata),
      .o_crc    (beat_crc)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         dmcrc_pkg::ST_IDLE: begin
            if (start) state_d = dmcrc_pkg::ST_FETCH;
         end
         dmcrc_pkg::ST_FETCH: begin
            if (fetch_ack && idx_q == `DMCRC_IDX_NEXT)
               state_d = dmcrc_pkg::ST_WAIT;
         end
         dmcrc_pkg::ST_WAIT: begin
            if (trig_q) state_d = dmcrc_pkg::ST_READ;
         end
         dmcrc_pkg::ST_READ: begin
            if (read_done)
               state_d = last_desc ? dmcrc_pkg::ST_CHECK
                                   : dmcrc_pkg::ST_FETCH;
         end
         dmcrc_pkg::ST_CHECK: begin
            state_d = cmp_value ? dmcrc_pkg::ST_FETCH
                                : dmcrc_pkg::ST_IDLE;
         end
         default: state_d = dmcrc_pkg::ST_IDLE;
      endcase
      if (!i_chan_enable) state_d = dmcrc_pkg::ST_IDLE;
   end

   // Init word is cut to 16 bits so CRC-16 compares on a clean register
   assign chk_d = reload ? (i_crc_polynomial_select ? i_mem_rdata
                             : {16'h0000, i_mem_rdata[15:0]})
                : read_ack ? beat_crc : chk_q;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= dmcrc_pkg::ST_IDLE;
         en_q    <= 1'b0;
         chk_q   <= `DMCRC_RST_WORD;
      end else begin
         state_q <= state_d;
         en_q    <= i_chan_enable;
         chk_q   <= chk_d;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         head_q <= `DMCRC_RST_WORD;
         desc_q <= `DMCRC_RST_WORD;
         idx_q  <= `DMCRC_IDX_COUNT;
      end else if (start) begin
         head_q <= i_first_descriptor_addr;
         desc_q <= i_first_descriptor_addr;
         idx_q  <= `DMCRC_IDX_COUNT;
      end else begin
         if (fetch_ack) idx_q <= idx_q + 2'h1;
         if (advance) desc_q <= last_desc ? head_q : next_q;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q  <= `DMCRC_RST_COUNT;
         src_q  <= `DMCRC_RST_WORD;
         next_q <= `DMCRC_LIST_END;
      end else if (fetch_ack) begin
         if (idx_q == `DMCRC_IDX_COUNT)  cnt_q  <= i_mem_rdata[15:0];
         if (idx_q == `DMCRC_IDX_SOURCE) src_q  <= i_mem_rdata;
         if (idx_q == `DMCRC_IDX_NEXT)   next_q <= i_mem_rdata;
      end else if (read_ack) begin
         cnt_q <= cnt_q - 16'h0001;
         src_q <= src_q + beat_step(i_crc_beat_width);
      end
   end

   // One pending trigger is remembered; extra ones while busy merge
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         active_q  <= 1'b0;
         trig_q    <= 1'b0;
         crc_err_q <= 1'b0;
         terr_q    <= 1'b0;
         tcmpl_q   <= 1'b0;
      end else begin
         active_q  <= (start | active_q) & i_chan_enable & ~mismatch;
         // A trigger left pending must not leak into the next enable
         trig_q    <= ((i_trigger & active_q) | (trig_q & ~consume))
                      & i_chan_enable;
         crc_err_q <= mismatch | (crc_err_q & ~i_clear_crc_error);
         terr_q    <= mismatch | (terr_q & ~i_clear_transfer_error);
         tcmpl_q   <= match | (tcmpl_q & ~i_clear_transfer_complete);
      end
   end

   assign o_mem_req  = (in_fetch | in_read) & (cnt_q != `DMCRC_RST_COUNT
                                               | in_fetch);
   assign o_mem_addr = in_fetch ? desc_q + fetch_ofs : src_q;
   assign o_channel_active                 = active_q;
   assign o_running_checksum               = chk_q;
   assign o_channel_crc_error_status       = crc_err_q;
   assign o_channel_transfer_error_flag    = terr_q;
   assign o_channel_transfer_complete_flag = tcmpl_q;
   assign o_terr_irq  = terr_q & i_terr_int_enable;
   assign o_tcmpl_irq = tcmpl_q & i_tcmpl_int_enable;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   property p_reload;
      reload |=> chk_q[15:0] == $past(i_mem_rdata[15:0]);
   endproperty
   a_reload: assert property (p_reload)
      else $error("checksum not reloaded from init word");

   property p_compare;
      in_check && i_crc_polynomial_select && chk_q == `DMCRC_MAGIC32
         |=> tcmpl_q && !$rose(terr_q);
   endproperty
   a_compare: assert property (p_compare)
      else $error("magic value not accepted");

   property p_mismatch;
      mismatch |=> crc_err_q && terr_q && !active_q
                   && state_q == dmcrc_pkg::ST_IDLE;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("mismatch did not stop channel");

   property p_terr_irq;
      mismatch && i_terr_int_enable ##1 i_terr_int_enable |-> o_terr_irq;
   endproperty
   a_terr_irq: assert property (p_terr_irq)
      else $error("error interrupt gating wrong");

   property p_match;
      match && i_chan_enable
         |=> tcmpl_q && active_q && state_q == dmcrc_pkg::ST_FETCH
                && desc_q == head_q && idx_q == `DMCRC_IDX_COUNT;
   endproperty
   a_match: assert property (p_match)
      else $error("good check did not refetch list head");

   property p_wait_trig;
      fetch_ack && idx_q == `DMCRC_IDX_NEXT && i_chan_enable
         |=> state_q == dmcrc_pkg::ST_WAIT;
   endproperty
   a_wait_trig: assert property (p_wait_trig)
      else $error("no wait for trigger after fetch");

   property p_beat_step;
      read_ack && i_chan_enable && !read_done
         |=> src_q == $past(src_q) + beat_step($past(i_crc_beat_width))
             && state_q == dmcrc_pkg::ST_READ;
   endproperty
   a_beat_step: assert property (p_beat_step)
      else $error("source address step wrong");

   property p_set_wins;
      mismatch && i_clear_transfer_error |=> terr_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag clear lost an error event");

   c_good:  cover property (match);
   c_bad:   cover property (mismatch);
   c_wrap:  cover property (match ##[1:40] consume);
   c_multi: cover property (read_done && !last_desc);
endmodule

/* File: tb/dmcrc_mem_model.sv */
// Behavioural system memory answering the monitor's read port
`timescale 1ns/1ps
module dmcrc_mem_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_mem_req,
   input  wire logic [31:0] i_mem_addr,
   output logic             o_mem_ack,
   output logic      [31:0] o_mem_rdata
);
   // Flat 16 KiB image; upper address bits are ignored
   logic [7:0]  mem [0:16383];
   logic [31:0] last;
   logic [13:0] a;
   integer      seed;
   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
      seed = 32'h3ACBA90A;
      last = 32'h0;
      o_mem_ack = 1'b0;
      o_mem_rdata = 32'h0;
   end
   // Random stalls; data lines toggle when no answer stands
   always @(negedge i_sys_clk) begin
      if (i_mem_req && ($random(seed) & 3) != 0) begin
         a = i_mem_addr[13:0];
         last = {mem[a + 14'h3], mem[a + 14'h2], mem[a + 14'h1], mem[a]};
         o_mem_ack = 1'b1;
      end else begin
         last = ~last;
         o_mem_ack = 1'b0;
      end
      o_mem_rdata = last;
   end
endmodule

/* File: tb/dmcrc_monitor_tb.sv */
// Self-checking bench for the DMA memory CRC monitor
`timescale 1ns/1ps
`include "dmcrc_map.svh"
module dmcrc_monitor_tb;
   localparam logic [31:0] HEAD = 32'h0000_1000;
   localparam logic [31:0] SRC  = 32'h0000_2000;
   logic        clk, rst, en, sel, trig, t_ie, c_ie, clr_c, clr_t, clr_k;
   logic        poly, req, ack, act, c_err, t_err, t_cmp, t_irq, c_irq;
   logic [1:0]  width;
   logic [31:0] addr, rdata, cks;
   integer      n_fail, n_tests, seed;

   dmcrc_monitor u_dmcrc_monitor (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_chan_enable(en),
      .i_crc_input_source(sel), .i_crc_polynomial_select(poly),
      .i_crc_beat_width(width), .i_first_descriptor_addr(HEAD),
      .i_trigger(trig), .i_terr_int_enable(t_ie),
      .i_tcmpl_int_enable(c_ie), .i_clear_crc_error(clr_c),
      .i_clear_transfer_error(clr_t), .i_clear_transfer_complete(clr_k),
      .o_mem_req(req), .o_mem_addr(addr), .i_mem_ack(ack),
      .i_mem_rdata(rdata), .o_channel_active(act),
      .o_running_checksum(cks), .o_channel_crc_error_status(c_err),
      .o_channel_transfer_error_flag(t_err),
      .o_channel_transfer_complete_flag(t_cmp),
      .o_terr_irq(t_irq), .o_tcmpl_irq(c_irq));
   dmcrc_mem_model u_dmcrc_mem_model (.i_sys_clk(clk), .i_mem_req(req),
      .i_mem_addr(addr), .o_mem_ack(ack), .o_mem_rdata(rdata));

   function automatic logic [31:0] crc_b(input logic [31:0] c,
                                         input logic [7:0] b, input logic p);
      if (p) c = c ^ {24'h0, b};
      else c[15:8] = c[15:8] ^ b;
      for (int i = 0; i < 8; i++)
         if (p) c = c[0] ? (c >> 1) ^ `DMCRC_POLY32 : c >> 1;
         else c[15:0] = c[15] ? (c[15:0] << 1) ^ `DMCRC_POLY16 : c[15:0] << 1;
      return c;
   endfunction
   // Undo 32 zero-bit steps of the reflected register
   function automatic logic [31:0] unshift(input logic [31:0] r);
      for (int i = 0; i < 32; i++)
         r = r[31] ? ((r ^ `DMCRC_POLY32) << 1) | 32'h1 : r << 1;
      return r;
   endfunction

   task check(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wr32(input logic [31:0] a, input logic [31:0] v);
      for (int j = 0; j < 4; j++)
         u_dmcrc_mem_model.mem[a + j] = v[8*j +: 8];
   endtask

   task automatic run(input logic p, input logic [1:0] w, input int nd, k,
                      input logic good, input logic ie);
      int step, n, tl, cyc;
      logic [31:0] c, init, fin, d_at;
      logic exp_m;
      step = (w == dmcrc_pkg::BEAT_BYTE) ? 1 :
             (w == dmcrc_pkg::BEAT_HALF) ? 2 : 4;
      n = nd * k * step;
      tl = p ? 4 : 2;
      init = $random(seed);
      c = p ? init : {16'h0, init[15:0]};
      for (int i = 0; i < n; i++) u_dmcrc_mem_model.mem[SRC + i] = $random(seed);
      for (int i = 0; i < n - tl; i++) c = crc_b(c, u_dmcrc_mem_model.mem[SRC + i], p);
      // The expected value is held so that its top byte sits lowest
      if (p) c = c ^ unshift(`DMCRC_MAGIC32);
      if (p) c = {c[7:0], c[15:8], c[23:16], c[31:24]};
      for (int j = 0; j < tl; j++)
         u_dmcrc_mem_model.mem[SRC + n - tl + j] =
            c[8*tl - 1 - 8*j -: 8];
      if (!good) u_dmcrc_mem_model.mem[SRC] = ~u_dmcrc_mem_model.mem[SRC];
      fin = p ? init : {16'h0, init[15:0]};
      for (int i = 0; i < n; i++) fin = crc_b(fin, u_dmcrc_mem_model.mem[SRC + i], p);
      exp_m = p ? (fin === `DMCRC_MAGIC32) : (fin[15:0] === 16'h0);
      for (int d = 0; d < nd; d++) begin
         d_at = HEAD + 16 * d;
         wr32(d_at, k);
         wr32(d_at + 32'h4, SRC + d * k * step);
         wr32(d_at + 32'h8, init);
         wr32(d_at + 32'hC, (d == nd - 1) ? `DMCRC_LIST_END : d_at + 32'h10);
      end
      poly = p; width = w; t_ie = ie; c_ie = ie; en = 1'b1;
      for (int r = 0; r < (exp_m ? 2 : 1); r++) begin
         for (cyc = 0; cyc < 1000 && t_cmp !== 1'b1 && c_err !== 1'b1; cyc++) begin
            @(negedge clk);
            trig = $random(seed);
         end
         check(t_cmp, exp_m);
         check(c_err, !exp_m);
         check(t_err, !exp_m);
         check(act, exp_m);
         check(c_irq, exp_m & ie);
         check(t_irq, !exp_m & ie);
         check(p ? cks : cks[15:0], p ? fin : fin[15:0]);
         if (exp_m) check({req, addr}, {1'b1, HEAD});
         clr_k = 1'b1;
         @(negedge clk);
         clr_k = 1'b0;
      end
      en = 1'b0; trig = 1'b0; clr_c = 1'b1; clr_t = 1'b1; clr_k = 1'b1;
      @(negedge clk);
      clr_c = 1'b0; clr_t = 1'b0; clr_k = 1'b0;
      @(negedge clk);
      $display("test done poly=%0d width=%0d descs=%0d", p, w, nd);
   endtask

   // Unrouted source keeps the channel idle; a reset in mid-fetch clears
   // all state, and an enable still high at release starts a new pass
   task automatic idle_and_reset();
      sel = 1'b0; en = 1'b1;
      repeat (4) @(negedge clk);
      check({act, req}, 2'h0);
      en = 1'b0;
      @(negedge clk);
      sel = 1'b1; en = 1'b1;
      repeat (6) @(negedge clk);
      check(act, 1'b1);
      rst = 1'b1;
      @(negedge clk);
      check({act, req, c_err, t_err, t_cmp}, 5'h00);
      check(cks, `DMCRC_RST_WORD);
      rst = 1'b0;
      @(negedge clk);
      check(act, 1'b1);
      en = 1'b0;
      repeat (2) @(negedge clk);
      $display("test done reset and unrouted source");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Longest legal run is far below this span
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
   initial begin
      {en, trig, t_ie, c_ie, clr_c, clr_t, clr_k, poly} = 8'h00;
      width = 2'h0; sel = 1'b1; rst = 1'b1;
      n_fail = 0; n_tests = 0; seed = 32'h3ACBA90A;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      run(1'b0, dmcrc_pkg::BEAT_BYTE, 1, 6, 1'b1, 1'b1);
      run(1'b1, dmcrc_pkg::BEAT_WORD, 2, 3, 1'b1, 1'b0);
      run(1'b1, dmcrc_pkg::BEAT_HALF, 1, 5, 1'b0, 1'b1);
      run(1'b0, dmcrc_pkg::BEAT_WORD, 2, 2, 1'b0, 1'b0);
      idle_and_reset();
      for (int t = 0; t < 4; t++)
         run($random(seed), 2'(($random(seed) & 32'h7FFF) % 3),
             1 + ($random(seed) & 1), 4 + ($random(seed) & 3),
             $random(seed), $random(seed));
      finish_test();
   end
endmodule
